// >>> rtl/irq_prio_pkg.sv
// constants, offsets and source tables of the interrupt priority logic
package irq_prio_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_PRIO_TIMERS_CALENDAR = 8'h00;
  localparam logic [7:0] OFF_PRIO_WATCHDOG_REFRESH_SERIAL = 8'h04;
  localparam logic [7:0] OFF_PRIO_EXT_PINS_LOW = 8'h08;
  localparam logic [7:0] OFF_PRIO_EXT_PINS_HIGH = 8'h0c;
  localparam logic [7:0] OFF_PRIO_DMA_FIFO_CONVERTER = 8'h10;
  localparam logic [7:0] OFF_NONMASKABLE_CONTROL = 8'h14;
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h18;

  // ---------------------------------------------------------------
  // reset values and writable bit masks
  // ---------------------------------------------------------------
  localparam logic [15:0] PRIO_RESET = 16'h0000;
  localparam logic [15:0] NMCTL_RESET = 16'h0000;
  localparam logic [4:0][15:0] PRIO_WMASK = {
    16'hf0ff, 16'h00ff, 16'hffff, 16'hfff0, 16'hffff};
  localparam int NMCTL_PIN_LEVEL_BIT = 15;
  localparam int NMCTL_EDGE_SEL_BIT = 8;
  localparam logic EDGE_SEL_RESET = 1'b0;

  // ---------------------------------------------------------------
  // sources, event codes and level table
  // ---------------------------------------------------------------
  localparam int SRC_COUNT = 23;
  localparam int ONCHIP_COUNT = 14;
  localparam int EXT_PIN_COUNT = 6;
  localparam int SYNC_STAGES = 2;
  localparam logic [11:0] LVL_CODE_BASE = 12'h200;
  localparam logic [3:0] LVL_MAX = 4'hf;
  localparam logic [3:0] LVL_MASKED = 4'h0;

  // group = register index * 4 + field (field 3 = bits 15:12)
  function automatic logic [4:0] src_group(input int idx);
    case (idx)
      0: return 5'h03;
      1: return 5'h02;
      2, 3: return 5'h01;
      4, 5, 6: return 5'h00;
      7, 8, 9, 10: return 5'h05;
      11: return 5'h07;
      12, 13: return 5'h06;
      14: return 5'h08;
      15: return 5'h09;
      16: return 5'h0a;
      17: return 5'h0b;
      18: return 5'h0c;
      19: return 5'h0d;
      20: return 5'h13;
      21: return 5'h11;
      default: return 5'h10;
    endcase
  endfunction

  // fixed event code; level-coded sources carry their alternate code
  function automatic logic [11:0] src_code(input int idx);
    case (idx)
      0: return 12'h400;
      1: return 12'h420;
      2: return 12'h440;
      3: return 12'h460;
      4: return 12'h480;
      5: return 12'h4a0;
      6: return 12'h4c0;
      7: return 12'h4e0;
      8: return 12'h500;
      9: return 12'h520;
      10: return 12'h540;
      11: return 12'h560;
      12: return 12'h580;
      13: return 12'h5a0;
      14: return 12'h600;
      15: return 12'h620;
      16: return 12'h640;
      17: return 12'h660;
      18: return 12'h680;
      19: return 12'h6a0;
      20: return 12'h800;
      21: return 12'h900;
      default: return 12'h980;
    endcase
  endfunction

  // level 15 -> 0x200, each lower level adds 0x20
  function automatic logic [11:0] level_code(input logic [3:0] lvl);
    logic [3:0] inv;
    inv = LVL_MAX - lvl;
    return LVL_CODE_BASE + {3'h0, inv, 5'h00};
  endfunction

endpackage

// >>> rtl/pin_sync.sv
// two-stage synchroniser for pin inputs plus one delayed copy
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_async,
  input wire logic [WIDTH-1:0] reset_level,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] level_prev
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  // the stages fill over three edges after release; level shows the idle
  // level for the first two and prev follows level until the third, so no false edge
  logic [1:0] fill_r;

  // ---------------------------------------------------------------
  // first stage read only by second stage
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      fill_r <= 2'h0;
    end else begin
      meta_r <= pin_async;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fill_r <= (fill_r == 2'h3) ? 2'h3 : fill_r + 2'h1;
    end
  end

  // level valid once the second stage holds a sample, prev one later
  assign level = (fill_r >= 2'h2) ? sync_r : reset_level;
  assign level_prev = (fill_r == 2'h3) ? prev_r : level;

endmodule

// >>> rtl/prio_select.sv
// picks the pending source with the highest level, lowest index on ties
`timescale 1ns/1ps
module prio_select #(
  parameter int N = 23
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0][3:0] level,
  output logic valid,
  output logic [4:0] index,
  output logic [3:0] best_level
);

  // scan downward so that equal levels leave the lowest index in place
  always_comb begin
    valid = 1'b0;
    index = 5'h00;
    best_level = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && level[i] != 4'h0 && level[i] >= best_level) begin
        valid = 1'b1;
        index = 5'(i);
        best_level = level[i];
      end
    end
  end

endmodule

// >>> rtl/irq_priority_vector_logic.sv
// interrupt priority registers, arbitration and event code generation
//
// Summary of operation
// - timer 0 underflow gives code 0x400, level from reg A bits 15:12.
// - timer 1 underflow gives code 0x420, level from reg A bits 11:8.
// - timer 2 underflow 0x440 and capture 0x460 share A 7:4.
// - refresh match 0x580 above overflow 0x5a0, both on B 11:8.
// - default order: timer 0 underflow first, converter last.
// - level-coded codes: level 15 is 0x200, plus 0x20 per lower level.
// - level-coded sources report the code of their accepted level.
// - five 16-bit read/write priority registers of four 4-bit fields.
// - priority registers clear on resets and hardware standby only.
// - field value 0 masks the source; 15 is the top level.
// - reserved priority fields read zero; software writes zero.
// - register D holds pin 5 in bits 7:4 and pin 4 in 3:0.
// - register E holds dma 15:12, fifo serial 7:4, converter 3:0.
// - non-maskable control is 16 bits, cleared on resets only.
// - control bit 15 reads the synchronised pin level, not writable.
// - control bit 8 selects the pin edge that raises a request.
// - control bits 14:9 and 7:0 read zero; software writes zero.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module irq_priority_vector_logic #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic manual_reset,
  input wire logic hw_standby,
  input wire logic [irq_prio_pkg::ONCHIP_COUNT-1:0] onchip_req,
  input wire logic [irq_prio_pkg::EXT_PIN_COUNT-1:0] ext_request_pin_n,
  input wire logic dma_req,
  input wire logic fifo_serial_req,
  input wire logic converter_req,
  input wire logic nonmaskable_pin,
  output logic irq_pending,
  output logic [3:0] irq_level,
  output logic [4:0] irq_source,
  output logic [11:0] event_code,
  output logic [11:0] event_code_alt,
  output logic nmi_request
);

  localparam int N = irq_prio_pkg::SRC_COUNT;
  localparam int NPIN = irq_prio_pkg::EXT_PIN_COUNT;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
    $error("ADDR_W must lie between 5 and 8");
  end
  if (N > 32) begin : g_bad_count
    $error("source index is five bits wide");
  end

  // ---------------------------------------------------------------
  // state of the block, apart from the pin synchroniser stages
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [4:0][15:0] prio;
    logic edge_sel;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic pending;
    logic [3:0] level;
    logic [4:0] source;
    logic [11:0] code;
    logic [11:0] code_alt;
    logic nmi_req;
  } state_t;

  localparam state_t STATE_RESET = '{
    prio: {5{irq_prio_pkg::PRIO_RESET}},
    edge_sel: irq_prio_pkg::EDGE_SEL_RESET,
    rdata: 32'h0000_0000,
    ready: 1'b0,
    slverr: 1'b0,
    pending: 1'b0,
    level: 4'h0,
    source: 5'h00,
    code: 12'h000,
    code_alt: 12'h000,
    nmi_req: 1'b0
  };

  state_t st_r;
  state_t st_nxt;

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  logic [NPIN:0] pin_level;
  logic [NPIN:0] pin_prev;
  logic nmi_level;
  logic nmi_prev;
  logic [NPIN-1:0] ext_active;

  // prev is seeded as the idle level so release makes no false edge
  pin_sync #(
    .WIDTH(NPIN + 1)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async({nonmaskable_pin, ext_request_pin_n}),
    .reset_level({1'b1, {NPIN{1'b1}}}),
    .level(pin_level),
    .level_prev(pin_prev)
  );

  assign nmi_level = pin_level[NPIN];
  assign nmi_prev = pin_prev[NPIN];
  // external request pins are level sensitive and active low
  assign ext_active = ~pin_level[NPIN-1:0];

  // ---------------------------------------------------------------
  // request vector in default order, index 0 highest
  // ---------------------------------------------------------------
  logic [N-1:0] req_vec;
  logic [N-1:0][3:0] src_level;

  // on-chip requests come from logic on pclk and need no sync
  assign req_vec = {converter_req, fifo_serial_req, dma_req,
                    ext_active, onchip_req};

  // each source reads the field of its group from the bank
  for (genvar i = 0; i < N; i++) begin : g_level
    localparam logic [4:0] GRP = irq_prio_pkg::src_group(i);
    assign src_level[i] =
      st_r.prio[GRP[4:2]][{GRP[1:0], 2'b00} +: 4];
  end

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  logic win_valid;
  logic [4:0] win_index;
  logic [3:0] win_level;

  // level 0 never wins, so a cleared field masks its source
  prio_select #(
    .N(N)
  ) u_prio_select (
    .req(req_vec),
    .level(src_level),
    .valid(win_valid),
    .index(win_index),
    .best_level(win_level)
  );

  // fixed code table, one entry per source
  logic [N-1:0][11:0] code_table;
  for (genvar i = 0; i < N; i++) begin : g_code
    assign code_table[i] = irq_prio_pkg::src_code(i);
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic setup_phase;
  logic write_commit;
  logic addr_hit;
  logic [2:0] reg_idx;
  logic [15:0] nmctl_read;
  logic [15:0] status_read;

  assign setup_phase = psel & ~penable;
  // a write lands at the edge where pready is sampled high
  assign write_commit = psel & penable & st_r.ready & pwrite & ~st_r.slverr;

  // word aligned, inside the seven-word window
  always_comb begin
    addr_hit = 1'b0;
    reg_idx = 3'h0;
    if (paddr[1:0] == 2'b00 &&
        paddr <= ADDR_W'(irq_prio_pkg::OFF_EVENT_STATUS)) begin
      addr_hit = 1'b1;
      reg_idx = paddr[4:2];
    end
  end

  // pin level at bit 15, edge select at bit 8, the rest reads zero
  always_comb begin
    nmctl_read = 16'h0000;
    nmctl_read[irq_prio_pkg::NMCTL_PIN_LEVEL_BIT] = nmi_level;
    nmctl_read[irq_prio_pkg::NMCTL_EDGE_SEL_BIT] = st_r.edge_sel;
  end

  // presented level over presented code
  assign status_read = {st_r.level, st_r.code};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // apb answer one cycle after setup, zero wait states
    st_nxt.ready = 1'b0;
    st_nxt.slverr = 1'b0;
    if (setup_phase) begin
      st_nxt.ready = 1'b1;
      st_nxt.slverr = ~addr_hit;
      st_nxt.rdata = 32'h0000_0000;
      if (!pwrite && addr_hit) begin
        case (reg_idx)
          3'h0, 3'h1, 3'h2, 3'h3, 3'h4: begin
            // stored reserved bits are always zero
            st_nxt.rdata = {16'h0000, st_r.prio[reg_idx]};
          end
          3'h5: begin
            st_nxt.rdata = {16'h0000, nmctl_read};
          end
          3'h6: begin
            st_nxt.rdata = {16'h0000, status_read};
          end
          default: begin
            st_nxt.rdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // register writes, reserved bits dropped by mask
    if (write_commit) begin
      case (reg_idx)
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4: begin
          st_nxt.prio[reg_idx] =
            pwdata[15:0] & irq_prio_pkg::PRIO_WMASK[reg_idx];
        end
        3'h5: begin
          // pin level bit is not storage, writes cannot touch it
          st_nxt.edge_sel =
            pwdata[irq_prio_pkg::NMCTL_EDGE_SEL_BIT];
        end
        default: begin
          st_nxt.edge_sel = st_r.edge_sel;
        end
      endcase
    end

    // clears win over a write landing in the same cycle
    if (manual_reset || hw_standby) begin
      st_nxt.prio = {5{irq_prio_pkg::PRIO_RESET}};
    end
    if (manual_reset) begin
      st_nxt.edge_sel = irq_prio_pkg::EDGE_SEL_RESET;
    end

    // presented request, refreshed every cycle
    st_nxt.pending = win_valid;
    st_nxt.level = win_valid ? win_level : irq_prio_pkg::LVL_MASKED;
    st_nxt.source = win_index;
    st_nxt.code = 12'h000;
    st_nxt.code_alt = 12'h000;
    if (win_valid) begin
      st_nxt.code_alt = code_table[win_index];
      if (win_index >= 5'(irq_prio_pkg::ONCHIP_COUNT)) begin
        st_nxt.code = irq_prio_pkg::level_code(win_level);
      end else begin
        st_nxt.code = code_table[win_index];
      end
    end

    // edge on the synchronised pin, direction from the select bit
    if (st_r.edge_sel) begin
      st_nxt.nmi_req = nmi_level & ~nmi_prev;
    end else begin
      st_nxt.nmi_req = ~nmi_level & nmi_prev;
    end
  end

  // ---------------------------------------------------------------
  // state register; software standby needs no term, nothing clears
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from the state register
  // ---------------------------------------------------------------
  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.slverr;
  assign irq_pending = st_r.pending;
  assign irq_level = st_r.level;
  assign irq_source = st_r.source;
  assign event_code = st_r.code;
  assign event_code_alt = st_r.code_alt;
  assign nmi_request = st_r.nmi_req;

endmodule

// >>> sim/irq_pvl_sva.sv
// assertion checker bound to the interrupt priority logic ports
`timescale 1ns/1ps
module irq_pvl_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_pending,
  input wire logic [3:0] irq_level,
  input wire logic [4:0] irq_source,
  input wire logic [11:0] event_code,
  input wire logic nmi_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  a_ready_one_cycle: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("pready is not a single cycle after setup");
  a_resv_b_zero: assert property (
    pready && !pslverr && paddr == 8'h04 |-> prdata[3:0] == 4'h0)
    else $error("reserved field of priority reg b not zero");
  a_resv_d_zero: assert property (
    pready && !pslverr && paddr == 8'h0c |-> prdata[15:8] == 8'h00)
    else $error("reserved fields of priority reg d not zero");
  a_ctl_zero_bits: assert property (
    pready && !pslverr && paddr == 8'h14
    |-> prdata[14:9] == 6'h00 && prdata[7:0] == 8'h00)
    else $error("reserved control bits not zero");
  // ------------------------------------------------------------
  // arbitration and event codes
  // ------------------------------------------------------------
  a_masked_never: assert property (
    irq_pending |-> irq_level != 4'h0)
    else $error("request presented at level zero");
  a_idle_clear: assert property (
    !irq_pending |-> irq_level == 4'h0 && event_code == 12'h000)
    else $error("idle outputs not cleared");
  a_onchip_code: assert property (
    irq_pending && irq_source < 5'd14
    |-> event_code == 12'h400 + {2'h0, irq_source, 5'h00})
    else $error("on-chip event code wrong");
  a_level_code: assert property (
    irq_pending && irq_source >= 5'd14
    |-> event_code == 12'h200 + {3'h0, 4'hf - irq_level, 5'h00})
    else $error("level-coded event code wrong");
  a_nmi_pulse: assert property (
    nmi_request |=> !nmi_request)
    else $error("edge request longer than one cycle");
  c_level_coded: cover property (irq_pending && irq_source >= 5'd14);
  c_nmi_seen: cover property (nmi_request);
  c_bus_error: cover property (pready && pslverr);
endmodule

bind irq_priority_vector_logic irq_pvl_sva #(.ADDR_W(ADDR_W))
  irq_pvl_sva_inst (.pclk, .presetn, .psel, .penable, .paddr,
  .prdata, .pready, .pslverr, .irq_pending, .irq_level,
  .irq_source, .event_code, .nmi_request);

// >>> sim/irq_src_model.sv
// peripheral and pin model feeding requests into the block
`timescale 1ns/1ps
module irq_src_model (
  input wire logic pclk,
  input wire logic [22:0] want,
  input wire logic nmi_want,
  output logic [13:0] onchip_req,
  output logic [5:0] ext_request_pin_n,
  output logic dma_req,
  output logic fifo_serial_req,
  output logic converter_req,
  output logic nonmaskable_pin
);
  // idle at time zero: no requests, pins high
  initial begin
    {onchip_req, dma_req, fifo_serial_req, converter_req} = '0;
    ext_request_pin_n = 6'h3f;
    nonmaskable_pin = 1'b1;
  end
  // levels held while service is wanted; pins pull low to request
  always @(posedge pclk) begin
    onchip_req <= want[13:0];
    ext_request_pin_n <= ~want[19:14];
    dma_req <= want[20];
    fifo_serial_req <= want[21];
    converter_req <= want[22];
    nonmaskable_pin <= nmi_want;
  end
endmodule

// >>> sim/irq_priority_vector_logic_tb_top.sv
// self-checking bench for the interrupt priority logic
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module irq_priority_vector_logic_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, irq_pending, nmi_request;
  logic manual_reset = 1'b0;
  logic hw_standby = 1'b0;
  logic [13:0] onchip_req;
  logic [5:0] ext_request_pin_n;
  logic dma_req, fifo_serial_req, converter_req, nonmaskable_pin;
  logic [3:0] irq_level;
  logic [4:0] irq_source;
  logic [11:0] event_code, event_code_alt;
  logic [22:0] want = 23'h0;
  logic nmi_want = 1'b1;
  int mismatches = 0;
  int comparisons = 0;
  int pulses = 0;
  localparam logic [15:0] msk [5] = '{16'hffff, 16'hfff0, 16'hffff,
    16'h00ff, 16'hf0ff};
  localparam logic [3:0] lvl [23] = '{4, 3, 2, 2, 1, 1, 1, 7, 7, 7, 7,
    9, 8, 8, 9, 10, 11, 12, 13, 14, 15, 6, 1};
  localparam logic [22:0] tie_req [5] = '{23'h0000c, 23'h00070,
    23'h00780, 23'h03000, 23'h03fff};
  localparam logic [4:0] tie_src [5] = '{2, 4, 7, 12, 0};
  localparam logic [7:0] ctl = irq_prio_pkg::OFF_NONMASKABLE_CONTROL;

  irq_priority_vector_logic irq_priority_vector_logic_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .manual_reset, .hw_standby, .onchip_req,
    .ext_request_pin_n, .dma_req, .fifo_serial_req, .converter_req,
    .nonmaskable_pin, .irq_pending, .irq_level, .irq_source,
    .event_code, .event_code_alt, .nmi_request);
  irq_src_model irq_src_model_inst (.pclk, .want, .nmi_want,
    .onchip_req, .ext_request_pin_n, .dma_req, .fifo_serial_req,
    .converter_req, .nonmaskable_pin);

  // clock and edge-request pulse counter
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (nmi_request === 1'b1) pulses++;

  // ------------------------------------------------------------
  // bus helpers
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one transfer; the wait is bounded so a dead slave cannot hang
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // look while settled; the answer stands until the next rising edge
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) mismatches++;
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, 8'(4 * i), 16'h0);
      `CHK("prio reset", 16'h0000, rd[15:0])
      xfer(1'b1, 8'(4 * i), 16'hffff);
      xfer(1'b0, 8'(4 * i), 16'h0);
      `CHK("prio mask", msk[i], rd[15:0])
      xfer(1'b1, 8'(4 * i), 16'h0);
    end
    xfer(1'b0, ctl, 16'h0);
    `CHK("ctl reset", 16'h8000, rd[15:0])
    xfer(1'b1, ctl, 16'hffff);
    xfer(1'b0, ctl, 16'h0);
    `CHK("ctl mask", 16'h8100, rd[15:0])
    xfer(1'b1, ctl, 16'h0);
    xfer(1'b0, 8'h1c, 16'h0);
    `CHK("unmapped err", 1'b1, err)
  endtask
  // each source alone; levels from the field values written
  task automatic t_codes();
    xfer(1'b1, 8'h00, 16'h4321);
    xfer(1'b1, 8'h04, 16'h9870);
    xfer(1'b1, 8'h08, 16'hcba9);
    xfer(1'b1, 8'h0c, 16'h00ed);
    xfer(1'b1, 8'h10, 16'hf061);
    for (int i = 0; i < 23; i++) begin
      want <= 23'(1) << i;
      cyc(7);
      `CHK("level", lvl[i], irq_level)
      `CHK("source", 5'(i), irq_source)
      if (i < 14) begin
        `CHK("code", 12'h400 + 12'(32 * i), event_code)
      end else begin
        `CHK("lcode", 12'h200 + 12'(32 * (15 - lvl[i])), event_code)
      end
      `CHK("alt", i < 14 ? 12'h400 + 12'(32 * i) :
        i < 20 ? 12'h600 + 12'(32 * (i - 14)) : i == 20 ? 12'h800 :
        i == 21 ? 12'h900 : 12'h980, event_code_alt)
    end
    xfer(1'b0, 8'h18, 16'h0);
    `CHK("status", 16'h13c0, rd[15:0])
  endtask
  // equal levels break by fixed order; higher level wins; 0 masks
  task automatic t_order();
    xfer(1'b1, 8'h00, 16'h2222);
    xfer(1'b1, 8'h04, 16'h2220);
    for (int i = 0; i < 5; i++) begin
      want <= tie_req[i];
      cyc(4);
      `CHK("tie", tie_src[i], irq_source)
    end
    xfer(1'b1, 8'h00, 16'h2262);
    want <= 23'h0000d;
    cyc(4);
    `CHK("level win", 5'd2, irq_source)
    xfer(1'b1, 8'h00, 16'h2202);
    want <= 23'h00004;
    cyc(4);
    `CHK("masked", 1'b0, irq_pending)
    want <= 23'h0;
    xfer(1'b1, 8'h00, 16'h0);
    xfer(1'b1, 8'h04, 16'h0);
  endtask
  // falling edge by default, rising after select is set
  task automatic t_nmi();
    pulses = 0;
    nmi_want <= 1'b0;
    cyc(8);
    `CHK("fall pulse", 1, pulses)
    xfer(1'b0, ctl, 16'h0);
    `CHK("pin low", 16'h0000, rd[15:0])
    nmi_want <= 1'b1;
    cyc(8);
    `CHK("no rise", 1, pulses)
    xfer(1'b1, ctl, 16'h0100);
    nmi_want <= 1'b0;
    cyc(8);
    nmi_want <= 1'b1;
    cyc(8);
    `CHK("rise pulse", 2, pulses)
  endtask
  // standby clears priorities only; manual reset clears control too
  task automatic t_standby();
    xfer(1'b1, 8'h00, 16'hffff);
    hw_standby <= 1'b1;
    cyc(1);
    hw_standby <= 1'b0;
    xfer(1'b0, 8'h00, 16'h0);
    `CHK("standby prio", 16'h0000, rd[15:0])
    xfer(1'b0, ctl, 16'h0);
    `CHK("standby ctl", 16'h8100, rd[15:0])
    manual_reset <= 1'b1;
    cyc(1);
    manual_reset <= 1'b0;
    xfer(1'b0, ctl, 16'h0);
    `CHK("manual ctl", 16'h8000, rd[15:0])
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence; the pin needs a few cycles to pass the synchroniser
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cyc(4);
    t_regs();
    t_codes();
    t_order();
    t_nmi();
    t_standby();
    wrap_up();
  end
  // watchdog well beyond the roughly 360 cycles the tests take
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
endmodule
